// [src/zcm_pkg.sv]
// constants, types and register map of the zero clamp and speed match block
package zcm_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_CTRL        = 8'h00; // method, allocation, motor type
  localparam logic [7:0] ADDR_CLAMP_ROT   = 8'h04; // clamp_level_rotary
  localparam logic [7:0] ADDR_CLAMP_LIN   = 8'h08; // clamp_level_linear
  localparam logic [7:0] ADDR_WIDTH_ROT   = 8'h0C; // match_width_rotary
  localparam logic [7:0] ADDR_WIDTH_LIN   = 8'h10; // match_width_linear
  localparam logic [7:0] ADDR_MAX_SPEED   = 8'h14; // motor maximum speed
  localparam logic [7:0] ADDR_POS_GAIN    = 8'h18; // position_loop_gain
  localparam logic [7:0] ADDR_POS_GAIN2   = 8'h1C; // second_position_gain
  localparam logic [7:0] ADDR_PRESET1     = 8'h20; // internal set speed 1
  localparam logic [7:0] ADDR_PRESET2     = 8'h24; // internal set speed 2
  localparam logic [7:0] ADDR_PRESET3     = 8'h28; // internal set speed 3
  localparam logic [7:0] ADDR_STATE       = 8'h2C; // live state, read only
  localparam logic [7:0] ADDR_IRQ_STAT    = 8'h30; // sticky events, write one to clear
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'h34; // interrupt enables
  localparam logic [7:0] ADDR_CLAMP_POS   = 8'h38; // position latched at clamp start

  // ****************************************
  // control register field positions
  // ****************************************
  localparam int CTRL_METHOD_LSB = 0;  // control_method_select [3:0]
  localparam int CTRL_ALLOC_BIT  = 4;  // input_alloc_mode
  localparam int CTRL_CIN_LSB    = 5;  // clamp_input_alloc [8:5]
  localparam int CTRL_MOUT_LSB   = 9;  // match_output_alloc [11:9]
  localparam int CTRL_LINEAR_BIT = 12; // 1 = linear motor units

  // ****************************************
  // reset values and limits
  // ****************************************
  localparam logic [15:0] CLAMP_LEVEL_RST = 16'h000A; // 10
  localparam logic [15:0] CLAMP_LEVEL_MAX = 16'h2710; // 10,000
  localparam logic [15:0] MATCH_WIDTH_RST = 16'h000A; // 10
  localparam logic [15:0] MATCH_WIDTH_MAX = 16'h0064; // 100
  localparam logic [15:0] MAX_SPEED_RST   = 16'h1770; // plain default, set per motor
  localparam logic [15:0] POS_GAIN_RST    = 16'h0100; // plain default
  localparam logic [3:0]  METHOD_RST      = 4'h0;     // speed control
  localparam logic [2:0]  MOUT_RST        = 3'h1;     // default output pin
  localparam logic [3:0]  CIN_ALWAYS_ON   = 4'h7;     // request forced active
  localparam logic [3:0]  CIN_PIN_LAST    = 4'h6;     // highest input pin code
  localparam int          GAIN_SHIFT      = 8;        // gain is 8.8 fixed point
  localparam int          NUM_GP_IN       = 7;        // allocatable input pins
  localparam int          NUM_GP_OUT      = 4;        // allocatable output pins
  localparam int          NUM_EV          = 5;        // interrupt events

  // ****************************************
  // types
  // ****************************************
  // active control method after switching
  typedef enum logic [1:0] {
    ZCM_M_SPEED    = 2'b00,
    ZCM_M_INTERNAL = 2'b01,
    ZCM_M_POSITION = 2'b10,
    ZCM_M_TORQUE   = 2'b11
  } zcm_method_t;

  // dedicated sequence pins, all active low at the connector
  typedef struct packed {
    logic zero_clamp_request_n;    // zero_clamp_request default pin
    logic preset_speed_sel_a_n;     // preset_speed_sel_a
    logic preset_speed_sel_b_n;     // preset_speed_sel_b
    logic dir_n;       // direction_select
    logic csel_n;      // control_select_input
    logic gain_sel_n;  // second position gain select
  } zcm_pins_t;

  // software configuration
  typedef struct packed {
    logic [3:0]  method;
    logic        alloc_mode;
    logic [3:0]  clamp_in;
    logic [2:0]  match_out;
    logic        linear;
    logic [15:0] clamp_rot;
    logic [15:0] clamp_lin;
    logic [15:0] width_rot;
    logic [15:0] width_lin;
    logic [15:0] max_speed;
    logic [15:0] gain1;
    logic [15:0] gain2;
    logic signed [15:0] preset1;
    logic signed [15:0] preset2;
    logic signed [15:0] preset3;
  } zcm_cfg_t;

endpackage : zcm_pkg

// [src/zcm_top.sv]
// zero clamp and speed coincidence supervision for a servo speed loop
`timescale 1ns/1ps
module zcm_top
  import zcm_pkg::*;
(
  input  wire logic                  core_clk,        // 50 MHz system clock
  input  wire logic                  rst_b,           // asynchronous reset, active low
  input  wire logic [7:0]            reg_addr,        // register byte address
  input  wire logic [31:0]           reg_wdata,       // register write data
  input  wire logic                  reg_wr,          // write strobe
  input  wire logic                  reg_rd,          // read strobe
  output logic      [31:0]           reg_rdata,       // read data, cycle after strobe
  input  wire zcm_pins_t             seq_pins_n,      // dedicated sequence pins
  input  wire logic [NUM_GP_IN-1:0]  gp_in_n,         // allocatable input pins
  input  wire logic signed [15:0]    speed_ref_input, // converted analog reference
  input  wire logic signed [15:0]    motor_speed,     // measured motor speed
  input  wire logic signed [31:0]    feedback_pos,    // encoder pulse count
  output logic signed [15:0]         speed_cmd,       // command to the speed loop
  output logic                       clamp_active,    // motor held by zero clamp
  output zcm_method_t                active_method,   // method in force now
  output logic                       speed_match_output, // coincidence, level
  output logic [NUM_GP_OUT-1:0]      match_pins,      // allocated output pins
  output logic                       irq              // level interrupt
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    zcm_pins_t              pin_s1;    // first sync stage
    zcm_pins_t              pin_s2;    // second sync stage
    logic [NUM_GP_IN-1:0]   gp_s1;     // first sync stage
    logic [NUM_GP_IN-1:0]   gp_s2;     // second sync stage
    zcm_cfg_t               cfg;       // software settings
    logic                   clamp;     // clamp in force
    logic signed [31:0]     hold_pos;  // position latched at clamp start
    logic                   displaced; // pushed beyond one pulse
    logic                   match;     // coincidence flag
    logic signed [15:0]     cmd;       // speed command
    zcm_method_t            method;    // active method
    logic [NUM_EV-1:0]      ev_stat;   // sticky events
    logic [NUM_EV-1:0]      ev_mask;   // event enables
    logic [31:0]            rdata;     // read data
  } zcm_state_t;

  zcm_state_t st_reg;   // registered state
  zcm_state_t st_next;  // next state

  // ****************************************
  // combinational working signals
  // ****************************************
  zcm_pins_t           pins;       // synchronised pins, active high
  logic [NUM_GP_IN-1:0] gp;        // synchronised inputs, active high
  logic                 speed_mode; // active method is a speed control
  logic                 clamp_ok;   // method code permits clamping
  logic                 request;    // zero_clamp_request after allocation
  logic signed [16:0]   ref_sel;    // reference before clamping
  logic signed [16:0]   preset;     // chosen internal set speed
  logic [16:0]          ref_mag;    // magnitude of reference
  logic [15:0]          level;      // clamp level for motor type
  logic [15:0]          level_eff;  // clamp level after speed limit
  logic [15:0]          width;      // match width for motor type
  logic                 clamp_cond; // clamp wanted this cycle
  logic signed [31:0]   pos_err;    // latched minus actual position
  logic signed [16:0]   err_sat;    // error limited to 17 bits
  logic signed [33:0]   loop_prod;  // error times gain
  logic signed [33:0]   loop_out;   // scaled loop output
  logic signed [33:0]   lim;        // speed limit, wide
  logic signed [16:0]   ref_eff;    // reference used for coincidence
  logic signed [17:0]   spd_diff;   // reference minus motor speed
  logic [17:0]          spd_mag;    // magnitude of difference
  logic                 match_now;  // coincidence this cycle
  logic [NUM_EV-1:0]    ev;         // events this cycle
  logic [NUM_EV-1:0]    w1c;        // clear mask from a write
  logic [31:0]          wd;         // write data alias

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    st_next = st_reg;
    wd      = reg_wdata;

    // two-stage synchronisers for connector pins
    st_next.pin_s1 = seq_pins_n;
    st_next.pin_s2 = st_reg.pin_s1;
    st_next.gp_s1  = gp_in_n;
    st_next.gp_s2  = st_reg.gp_s1;
    pins = ~st_reg.pin_s2;
    gp   = ~st_reg.gp_s2;

    // method switching by control select input
    speed_mode = 1'b1;
    clamp_ok   = 1'b1;
    st_next.method = ZCM_M_SPEED;
    case (st_reg.cfg.method)
      4'h0: st_next.method = ZCM_M_SPEED;
      4'h3: st_next.method = ZCM_M_INTERNAL;
      4'h4: st_next.method = pins.csel_n ? ZCM_M_SPEED : ZCM_M_INTERNAL;
      4'h5: st_next.method = pins.csel_n ? ZCM_M_POSITION : ZCM_M_INTERNAL;
      4'h6: st_next.method = pins.csel_n ? ZCM_M_TORQUE : ZCM_M_INTERNAL;
      4'h7: st_next.method = pins.csel_n ? ZCM_M_SPEED : ZCM_M_POSITION;
      4'h9: st_next.method = pins.csel_n ? ZCM_M_SPEED : ZCM_M_TORQUE;
      4'hA: st_next.method = ZCM_M_SPEED;
      4'h1: begin
        st_next.method = ZCM_M_POSITION;
        clamp_ok = 1'b0;
      end
      4'h2: begin
        st_next.method = ZCM_M_TORQUE;
        clamp_ok = 1'b0;
      end
      default: begin
        st_next.method = ZCM_M_POSITION;
        clamp_ok = 1'b0;
      end
    endcase
    // clamping and matching need a speed method right now
    speed_mode = (st_reg.method == ZCM_M_SPEED) || (st_reg.method == ZCM_M_INTERNAL);

    // request source: default pin or allocated input
    request = 1'b0;
    if (!st_reg.cfg.alloc_mode) begin
      request = pins.zero_clamp_request_n;
    end else if (st_reg.cfg.clamp_in <= CIN_PIN_LAST) begin
      request = gp[st_reg.cfg.clamp_in[2:0]];
    end else if (st_reg.cfg.clamp_in == CIN_ALWAYS_ON) begin
      request = 1'b1;
    end

    // internal set speed chosen by the preset pins, sign by direction
    case ({pins.preset_speed_sel_b_n, pins.preset_speed_sel_a_n})
      2'b01:   preset = 17'(st_reg.cfg.preset1);
      2'b10:   preset = 17'(st_reg.cfg.preset2);
      2'b11:   preset = 17'(st_reg.cfg.preset3);
      default: preset = '0;
    endcase
    if (pins.dir_n) begin
      preset = -preset;
    end
    ref_sel = (st_reg.method == ZCM_M_INTERNAL) ? preset : 17'(speed_ref_input);
    ref_mag = ref_sel[16] ? 17'(-ref_sel) : 17'(ref_sel);

    // clamp level per motor type, limited to maximum speed
    level     = st_reg.cfg.linear ? st_reg.cfg.clamp_lin : st_reg.cfg.clamp_rot;
    level_eff = (level > st_reg.cfg.max_speed) ? st_reg.cfg.max_speed : level;
    width     = st_reg.cfg.linear ? st_reg.cfg.width_lin : st_reg.cfg.width_rot;

    // clamp decision
    clamp_cond = clamp_ok && speed_mode && request && (ref_mag <= {1'b0, level_eff});
    st_next.clamp = clamp_cond;
    if (clamp_cond && !st_reg.clamp) begin
      st_next.hold_pos = feedback_pos;
    end

    // internal position loop toward the latched position
    pos_err = st_reg.hold_pos - feedback_pos;
    if (pos_err > 32'sd65535) begin
      err_sat = 17'sh0FFFF;
    end else if (pos_err < -32'sd65535) begin
      err_sat = -17'sh0FFFF;
    end else begin
      err_sat = pos_err[16:0];
    end
    loop_prod = 34'(err_sat) * $signed({18'h0, (pins.gain_sel_n ? st_reg.cfg.gain2 : st_reg.cfg.gain1)});
    loop_out  = loop_prod >>> GAIN_SHIFT;
    lim       = 34'(st_reg.cfg.max_speed);
    if (loop_out > lim) begin
      loop_out = lim;
    end else if (loop_out < -lim) begin
      loop_out = -lim;
    end
    // displacement beyond one pulse while clamped
    st_next.displaced = st_reg.clamp && ((pos_err > 32'sd1) || (pos_err < -32'sd1));

    // speed command: loop output while clamped and displaced, zero while held or outside speed methods, else reference
    if (st_reg.clamp) begin
      if (st_next.displaced) begin
        st_next.cmd = loop_out[15:0];
      end else begin
        st_next.cmd = '0;
      end
    end else if (speed_mode) begin
      st_next.cmd = ref_sel[15:0];
    end else begin
      st_next.cmd = '0;
    end

    // speed coincidence
    ref_eff   = st_reg.clamp ? 17'sh0 : ref_sel;
    spd_diff  = 18'(ref_eff) - 18'(motor_speed);
    spd_mag   = spd_diff[17] ? 18'(-spd_diff) : 18'(spd_diff);
    match_now = speed_mode && (spd_mag <= {2'b00, width});
    st_next.match = match_now;

    // events, set wins over clear
    ev[0] = st_next.clamp && !st_reg.clamp;         // clamp started
    ev[1] = !st_next.clamp && st_reg.clamp;         // clamp released
    ev[2] = st_next.match && !st_reg.match;         // coincidence reached
    ev[3] = !st_next.match && st_reg.match;         // coincidence lost
    ev[4] = st_next.displaced && !st_reg.displaced; // clamp pushed off
    w1c = '0;
    if (reg_wr && (reg_addr == ADDR_IRQ_STAT)) begin
      w1c = wd[NUM_EV-1:0];
    end
    st_next.ev_stat = (st_reg.ev_stat & ~w1c) | ev;

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CTRL: begin
          st_next.cfg.method     = wd[CTRL_METHOD_LSB +: 4];
          st_next.cfg.alloc_mode = wd[CTRL_ALLOC_BIT];
          st_next.cfg.clamp_in   = wd[CTRL_CIN_LSB +: 4];
          st_next.cfg.match_out  = wd[CTRL_MOUT_LSB +: 3];
          st_next.cfg.linear     = wd[CTRL_LINEAR_BIT];
        end
        ADDR_CLAMP_ROT: st_next.cfg.clamp_rot = (wd[15:0] > CLAMP_LEVEL_MAX) ? CLAMP_LEVEL_MAX : wd[15:0];
        ADDR_CLAMP_LIN: st_next.cfg.clamp_lin = (wd[15:0] > CLAMP_LEVEL_MAX) ? CLAMP_LEVEL_MAX : wd[15:0];
        ADDR_WIDTH_ROT: st_next.cfg.width_rot = (wd[15:0] > MATCH_WIDTH_MAX) ? MATCH_WIDTH_MAX : wd[15:0];
        ADDR_WIDTH_LIN: st_next.cfg.width_lin = (wd[15:0] > MATCH_WIDTH_MAX) ? MATCH_WIDTH_MAX : wd[15:0];
        ADDR_MAX_SPEED: st_next.cfg.max_speed = wd[15:0];
        ADDR_POS_GAIN:  st_next.cfg.gain1     = wd[15:0];
        ADDR_POS_GAIN2: st_next.cfg.gain2     = wd[15:0];
        ADDR_PRESET1:   st_next.cfg.preset1   = wd[15:0];
        ADDR_PRESET2:   st_next.cfg.preset2   = wd[15:0];
        ADDR_PRESET3:   st_next.cfg.preset3   = wd[15:0];
        ADDR_IRQ_MASK:  st_next.ev_mask       = wd[NUM_EV-1:0];
        default: ;  // read-only or unmapped: ignored
      endcase
    end

    // register reads, data stand for one cycle only
    st_next.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL: begin
          st_next.rdata[CTRL_METHOD_LSB +: 4] = st_reg.cfg.method;
          st_next.rdata[CTRL_ALLOC_BIT]       = st_reg.cfg.alloc_mode;
          st_next.rdata[CTRL_CIN_LSB +: 4]    = st_reg.cfg.clamp_in;
          st_next.rdata[CTRL_MOUT_LSB +: 3]   = st_reg.cfg.match_out;
          st_next.rdata[CTRL_LINEAR_BIT]      = st_reg.cfg.linear;
        end
        ADDR_CLAMP_ROT: st_next.rdata[15:0] = st_reg.cfg.clamp_rot;
        ADDR_CLAMP_LIN: st_next.rdata[15:0] = st_reg.cfg.clamp_lin;
        ADDR_WIDTH_ROT: st_next.rdata[15:0] = st_reg.cfg.width_rot;
        ADDR_WIDTH_LIN: st_next.rdata[15:0] = st_reg.cfg.width_lin;
        ADDR_MAX_SPEED: st_next.rdata[15:0] = st_reg.cfg.max_speed;
        ADDR_POS_GAIN:  st_next.rdata[15:0] = st_reg.cfg.gain1;
        ADDR_POS_GAIN2: st_next.rdata[15:0] = st_reg.cfg.gain2;
        ADDR_PRESET1:   st_next.rdata[15:0] = st_reg.cfg.preset1;
        ADDR_PRESET2:   st_next.rdata[15:0] = st_reg.cfg.preset2;
        ADDR_PRESET3:   st_next.rdata[15:0] = st_reg.cfg.preset3;
        ADDR_STATE:     st_next.rdata[5:0]  = {request, st_reg.displaced, st_reg.method,
                                               st_reg.match, st_reg.clamp};
        ADDR_IRQ_STAT:  st_next.rdata[NUM_EV-1:0] = st_reg.ev_stat;
        ADDR_IRQ_MASK:  st_next.rdata[NUM_EV-1:0] = st_reg.ev_mask;
        ADDR_CLAMP_POS: st_next.rdata = st_reg.hold_pos;
        default:        st_next.rdata = '0;  // unmapped reads zero
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg               <= '0;
      st_reg.pin_s1        <= '1;  // idle pins are open, read high
      st_reg.pin_s2        <= '1;
      st_reg.gp_s1         <= '1;
      st_reg.gp_s2         <= '1;
      st_reg.cfg.method    <= METHOD_RST;
      st_reg.cfg.match_out <= MOUT_RST;
      st_reg.cfg.clamp_rot <= CLAMP_LEVEL_RST;
      st_reg.cfg.clamp_lin <= CLAMP_LEVEL_RST;
      st_reg.cfg.width_rot <= MATCH_WIDTH_RST;
      st_reg.cfg.width_lin <= MATCH_WIDTH_RST;
      st_reg.cfg.max_speed <= MAX_SPEED_RST;
      st_reg.cfg.gain1     <= POS_GAIN_RST;
      st_reg.cfg.gain2     <= POS_GAIN_RST;
      st_reg.method        <= ZCM_M_SPEED;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // match output steered to the allocated pin
  always_comb begin
    match_pins = '0;
    if ((st_reg.cfg.match_out != 3'h0) && (st_reg.cfg.match_out <= 3'(NUM_GP_OUT))) begin
      match_pins[st_reg.cfg.match_out[1:0] - 2'd1] = st_reg.match;
    end
  end

  assign reg_rdata          = st_reg.rdata;
  assign speed_cmd          = st_reg.cmd;
  assign clamp_active       = st_reg.clamp;
  assign active_method      = st_reg.method;
  assign speed_match_output = st_reg.match;
  assign irq                = |(st_reg.ev_stat & st_reg.ev_mask);

endmodule : zcm_top

// [verif/tb_top.sv]
// self-checking bench for the zero clamp and speed match block
`timescale 1ns/1ps
module tb_top
  import zcm_pkg::*;
;
  logic                  core_clk, rst_b, reg_wr, reg_rd, rd_d, e, irq, clamp_active, speed_match_output;
  logic [7:0]            reg_addr;
  logic [31:0]           reg_wdata, reg_rdata, rnd;
  logic [31:0]           exp_q[$]; // expected read data, oldest first
  zcm_pins_t             seq_pins_n;
  logic [NUM_GP_IN-1:0]  gp_in_n;
  logic [NUM_GP_OUT-1:0] match_pins;
  logic signed [15:0]    speed_ref_input, motor_speed, speed_cmd, r;
  logic signed [31:0]    feedback_pos, kick;
  zcm_method_t           active_method;
  logic signed [4:0]     dd;
  int                    fails, compares;
  logic [15:0]           lv[5] = '{16'h2710, 16'h2710, 16'h000A, 16'h000A, 16'h000A};
  logic signed [15:0]    rf[5] = '{16'sh1B58, 16'sh1770, 16'sh000B, 16'shFFF6, 16'sh0000};
  logic signed [4:0]     bd[4] = '{5'sh0A, 5'sh16, 5'sh0B, 5'sh15}; // width edges
  zcm_top dut (.*);
  zcm_plant u_plant (.core_clk(core_clk), .rst_b(rst_b), .speed_cmd(speed_cmd), .kick(kick),
    .feedback_pos(feedback_pos));
  always #10 core_clk = ~core_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  // clamp expected for a method code and control select level
  function automatic logic clamp_ok(input logic [3:0] m, input logic c);
    case (m)
      4'h0, 4'h3, 4'h4, 4'hA: return 1'b1;
      4'h5, 4'h6: return !c;
      4'h7, 4'h9: return c;
      default: return 1'b0;
    endcase
  endfunction : clamp_ok
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      fails++;
      $display("mismatch %s exp %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic final_report;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  // one register access; for a read d is the expected data
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    if (!w)
      exp_q.push_back(d);
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask : acc
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  // read data stands in the cycle after the strobe
  always @(posedge core_clk) begin
    if (rd_d)
      chk("reg_rdata", reg_rdata, exp_q.pop_front());
    rd_d <= reg_rd;
  end
  initial begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    seq_pins_n = 6'h3F;
    gp_in_n = 7'h7F;
    {speed_ref_input, motor_speed, kick} = '0;
    rnd = 32'h00012E0C;
    cyc(4);
    rst_b <= 1'b1;
    acc(0, ADDR_CLAMP_ROT, 32'h0000000A);
    acc(0, ADDR_WIDTH_ROT, 32'h0000000A);
    acc(1, ADDR_CLAMP_LIN, 32'h00004E20);
    acc(0, ADDR_CLAMP_LIN, 32'h00002710);
    acc(1, ADDR_WIDTH_LIN, 32'h000000C8);
    acc(0, ADDR_WIDTH_LIN, 32'h00000064);
    acc(0, 8'h40, 32'h0);
    $display("test registers done");
    // level, reference and expected clamp per row
    for (int i = 0; i < 5; i++) begin
      acc(1, ADDR_CLAMP_ROT, {16'h0, lv[i]});
      speed_ref_input <= rf[i];
      seq_pins_n.zero_clamp_request_n <= 1'b0;
      cyc(5);
      chk("clamp_on", clamp_active, 5'h1A >> i & 5'h01);
      seq_pins_n.zero_clamp_request_n <= 1'b1;
      cyc(5);
      chk("clamp_off", clamp_active, 1'b0);
    end
    seq_pins_n.zero_clamp_request_n <= 1'b0;
    cyc(5);
    kick <= 32'sh5;
    @(posedge core_clk);
    kick <= 32'sh0;
    cyc(2);
    chk("speed_cmd_kick", speed_cmd, 16'shFFFB);
    for (int i = 0; i < 64 && speed_cmd !== 16'sh0; i++)
      @(posedge core_clk);
    chk("speed_cmd_back", speed_cmd, 16'sh0);
    if (speed_cmd !== 16'sh0)
      final_report();
    acc(0, ADDR_STATE, 32'h00000023);
    $display("test clamp done");
    for (int k = 0; k < 32; k++) begin
      seq_pins_n.csel_n <= !k[4];
      acc(1, ADDR_CTRL, {20'h0, 3'h1, 4'h0, 1'b0, k[3:0]});
      cyc(6);
      chk("clamp_method", clamp_active, clamp_ok(k[3:0], k[4]));
    end
    acc(1, ADDR_CTRL, 32'h0000020A);
    seq_pins_n.zero_clamp_request_n <= 1'b1;
    cyc(5);
    chk("clamp_req_off", clamp_active, 1'b0);
    acc(1, ADDR_CTRL, {19'h0, 1'b0, 3'h1, CIN_ALWAYS_ON, 1'b1, 4'h0});
    cyc(5);
    chk("clamp_forced", clamp_active, 1'b1);
    acc(1, ADDR_CTRL, 32'h00000250);
    gp_in_n[2] <= 1'b0;
    cyc(5);
    chk("clamp_gp_on", clamp_active, 1'b1);
    gp_in_n <= 7'h7F;
    cyc(5);
    chk("clamp_gp_off", clamp_active, 1'b0);
    $display("test methods done");
    for (int j = 0; j < 16; j++) begin
      rnd = lfsr(rnd);
      dd = (j < 4) ? bd[j] : $signed(rnd[20:16]);
      r = {4'h0, rnd[11:0]} + 16'sh0100;
      e = (dd >= -5'sd10) && (dd <= 5'sd10);
      acc(1, ADDR_CTRL, {20'h0, {1'b0, j[1:0]} + 3'h1, 9'h0});
      speed_ref_input <= r;
      motor_speed <= r + dd;
      cyc(3);
      chk("speed_match", speed_match_output, e);
      chk("match_pins", match_pins, {3'h0, e} << j[1:0]);
    end
    motor_speed <= speed_ref_input;
    acc(1, ADDR_CTRL, 32'h00000201);
    cyc(3);
    chk("match_position", speed_match_output, 1'b0);
    chk("method_position", active_method, ZCM_M_POSITION);
    $display("test match done");
    chk("irq_masked", irq, 1'b0);
    acc(1, ADDR_IRQ_MASK, 32'h0000000C);
    chk("irq_on", irq, 1'b1);
    acc(0, ADDR_IRQ_STAT, 32'h0000001F);
    acc(1, ADDR_IRQ_STAT, 32'h0000001F);
    acc(0, ADDR_IRQ_STAT, 32'h0);
    chk("irq_off", irq, 1'b0);
    $display("test interrupt done");
    final_report();
  end
endmodule : tb_top

// [verif/zcm_monitor.sv]
// port assertions for the zero clamp and speed match block
`timescale 1ns/1ps
module zcm_monitor
  import zcm_pkg::*;
(
  input wire logic                  core_clk,
  input wire logic                  rst_b,
  input wire logic [7:0]            reg_addr,
  input wire logic                  reg_rd,
  input wire logic [31:0]           reg_rdata,
  input wire logic signed [15:0]    speed_ref_input,
  input wire logic signed [15:0]    motor_speed,
  input wire logic signed [31:0]    feedback_pos,
  input wire logic signed [15:0]    speed_cmd,
  input wire logic                  clamp_active,
  input wire zcm_method_t           active_method,
  input wire logic                  speed_match_output,
  input wire logic [NUM_GP_OUT-1:0] match_pins
);
  logic [15:0]        ref_mag; // reference magnitude
  logic signed [16:0] err_s;   // reference minus motor speed
  logic [16:0]        err_mag; // its magnitude
  assign ref_mag = speed_ref_input[15] ? -speed_ref_input : speed_ref_input;
  assign err_s = speed_ref_input - motor_speed;
  assign err_mag = err_s[16] ? -err_s : err_s;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  chk_match_pins: assert property (match_pins != 4'h0 |-> speed_match_output && $onehot(match_pins))
    else $error("match pin without match");
  chk_hold_still: assert property (($rose(clamp_active) && $stable(feedback_pos)) ##1
    (clamp_active && $stable(feedback_pos)) [*2] |-> speed_cmd == 16'sh0)
    else $error("command while held in place");
  chk_clamp_method: assert property (clamp_active |-> !active_method[1] || !$past(active_method[1]))
    else $error("clamp outside speed control");
  chk_match_method: assert property (active_method[1] && $past(active_method[1]) |-> !speed_match_output)
    else $error("match outside speed control");
  chk_clamp_ref: assert property ($rose(clamp_active) && $past(active_method) == ZCM_M_SPEED
    |-> $past(ref_mag) <= CLAMP_LEVEL_MAX)
    else $error("clamp with large reference");
  chk_match_width: assert property ($past(active_method) == ZCM_M_SPEED && active_method == ZCM_M_SPEED
    && !$past(clamp_active) && !clamp_active && $past(err_mag) > 17'h00064 |-> !speed_match_output)
    else $error("match with wide speed error");
  chk_state_read: assert property ($past(reg_rd && reg_addr == ADDR_STATE) |->
    reg_rdata[3:0] == {$past(active_method), $past(speed_match_output), $past(clamp_active)})
    else $error("state read wrong");
endmodule : zcm_monitor
bind zcm_top zcm_monitor u_mon (.*);

// [verif/zcm_plant.sv]
// motor and load: one pulse per cycle toward the command, plus kicks
`timescale 1ns/1ps
module zcm_plant (
  input  wire logic               core_clk,
  input  wire logic               rst_b,
  input  wire logic signed [15:0] speed_cmd,
  input  wire logic signed [31:0] kick,
  output logic signed [31:0]      feedback_pos
);
  // an external force wins over the drive
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b)
      feedback_pos <= 32'sh0;
    else if (kick != 32'sh0)
      feedback_pos <= feedback_pos + kick;
    else if (speed_cmd != 16'sh0)
      feedback_pos <= feedback_pos + (speed_cmd[15] ? -32'sh1 : 32'sh1);
  end
endmodule : zcm_plant
